/* hw/dbp_pkg.sv */
// dbp_pkg: register map, field positions and reset values of the dual
// byte port.
// assumes 32-bit Avalon-MM word access, byte addresses, low byte used.
package dbp_pkg;
	localparam int ADDR_W = 5;
	localparam int PORT_W = 8;

	localparam logic [ADDR_W-1:0] OFF_FIRST_PINS = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_FIRST_LATCH = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_FIRST_DIR = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_SECOND_PINS = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_SECOND_LATCH = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_SECOND_DIR = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_PORT_E_CTRL = 5'h18;

	localparam logic [PORT_W-1:0] DIR_RST = 8'hFF;
	localparam logic [PORT_W-1:0] CTRL_RST = 8'h07;
	localparam logic [23:0] RDATA_PAD = 24'h00_0000;

	localparam int CTRL_IN_FULL_BIT = 7;
	localparam int CTRL_OUT_FULL_BIT = 6;
	localparam int CTRL_OVERRUN_BIT = 5;
	localparam int CTRL_MODE_BIT = 4;
	localparam int CTRL_DIR_MSB = 2;

	// first-port pin that carries capture_compare_unit2 when routed there
	localparam int CCU2_PIN = 1;

	localparam int SYNC_STAGES = 3;
endpackage

/* hw/dbp_pin_sync.sv */
// dbp_pin_sync: three-flop pin synchroniser with agreement filter.
// assumes pins are asynchronous to the core clock.
`timescale 1ns/1ps
module dbp_pin_sync
	import dbp_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
	logic [WIDTH-1:0] s1_next, s2_next, s3_next, lvl_next;

	// a bit only moves when stage two and three agree
	always_comb begin
		s1_next = pin_in;
		s2_next = s1_reg;
		s3_next = s2_reg;
		lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg ^ s3_reg));
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			lvl_reg <= '0;
		end else if (ce_in) begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			lvl_reg <= lvl_next;
		end
	end

	assign level_out = lvl_reg;
endmodule // dbp_pin_sync

/* hw/dbp_port.sv */
// dbp_port: two byte-wide general purpose ports behind an Avalon-MM slave,
// first port with peripheral override, second port with slave bus mode.
// assumes peripherals and slave bus strobes run on CORE_CLK_IN; pins are
// asynchronous and pass the synchroniser.
`timescale 1ns/1ps
module dbp_port
	import dbp_pkg::*;
(
	// clock, reset, enable
	input wire logic CORE_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic CLK_EN_IN,
	// register bus
	input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// first port pins
	input wire logic [PORT_W-1:0] FIRST_PIN_IN,
	output logic [PORT_W-1:0] FIRST_PIN_OUT,
	output logic [PORT_W-1:0] FIRST_PIN_OE_OUT,
	output logic [PORT_W-1:0] FIRST_PIN_LEVEL_OUT,
	// peripheral override, one bit per first-port pin
	input wire logic [PORT_W-1:0] PERIPH_SEL_IN,
	input wire logic [PORT_W-1:0] PERIPH_OUT_IN,
	input wire logic [PORT_W-1:0] PERIPH_OE_IN,
	// capture_compare_unit2 and its routing bit
	input wire logic CCU2_PIN_ROUTE_IN,
	input wire logic CCU2_SEL_IN,
	input wire logic CCU2_OUT_IN,
	input wire logic CCU2_OE_IN,
	// second port pins
	input wire logic [PORT_W-1:0] SECOND_PIN_IN,
	output logic [PORT_W-1:0] SECOND_PIN_OUT,
	output logic [PORT_W-1:0] SECOND_PIN_OE_OUT,
	// parallel_slave_bus handshake side
	input wire logic SLAVE_WR_STROBE_IN,
	input wire logic SLAVE_RD_STROBE_IN,
	input wire logic SLAVE_DRIVE_IN,
	output logic SLAVE_BUS_MODE_OUT,
	output logic INPUT_WORD_FULL_OUT,
	output logic OUTPUT_WORD_FULL_OUT,
	output logic INPUT_WORD_OVERRUN_OUT,
	output logic [CTRL_DIR_MSB:0] PORT_E_DIR_OUT
);
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	logic [PORT_W-1:0] first_lvl, second_lvl;

	dbp_pin_sync #(
		.WIDTH(2 * PORT_W)
	) u_sync (
		.clk_in(CORE_CLK_IN),
		.rstn_in(RSTN_IN),
		.ce_in(CLK_EN_IN),
		.pin_in({SECOND_PIN_IN, FIRST_PIN_IN}),
		.level_out({second_lvl, first_lvl})
	);

	// bus slave: one wait cycle, read data captured in it
	logic req, take, wr_go, rd_go;
	logic [PORT_W-1:0] wd;
	logic ack_reg, ack_next;
	logic [PORT_W-1:0] rdata_reg, rdata_next;

	assign req = AVS_READ_IN | AVS_WRITE_IN;
	assign take = ack_reg & CLK_EN_IN;
	assign AVS_WAITREQUEST_OUT = req & ~take;
	assign wr_go = AVS_WRITE_IN & take & AVS_BYTEENABLE_IN[0];
	assign rd_go = AVS_READ_IN & take;
	assign wd = AVS_WRITEDATA_IN[PORT_W-1:0];
	assign AVS_READDATA_OUT = {RDATA_PAD, rdata_reg};

	logic wr_f_pins, wr_f_lat, wr_f_dir;
	logic wr_s_pins, wr_s_lat, wr_s_dir, wr_ctrl, rd_s_pins;
	assign wr_f_pins = wr_go & hit(AVS_ADDRESS_IN, OFF_FIRST_PINS);
	assign wr_f_lat = wr_go & hit(AVS_ADDRESS_IN, OFF_FIRST_LATCH);
	assign wr_f_dir = wr_go & hit(AVS_ADDRESS_IN, OFF_FIRST_DIR);
	assign wr_s_pins = wr_go & hit(AVS_ADDRESS_IN, OFF_SECOND_PINS);
	assign wr_s_lat = wr_go & hit(AVS_ADDRESS_IN, OFF_SECOND_LATCH);
	assign wr_s_dir = wr_go & hit(AVS_ADDRESS_IN, OFF_SECOND_DIR);
	assign wr_ctrl = wr_go & hit(AVS_ADDRESS_IN, OFF_PORT_E_CTRL);
	assign rd_s_pins = rd_go & hit(AVS_ADDRESS_IN, OFF_SECOND_PINS);

	// control state
	logic [PORT_W-1:0] fdir_reg, fdir_next, sdir_reg, sdir_next;
	logic [CTRL_DIR_MSB:0] edir_reg, edir_next;
	logic mode_reg, mode_next, ibf_reg, ibf_next;
	logic obf_reg, obf_next, input_word_overrun_reg, input_word_overrun_next;
	logic [PORT_W-1:0] inbuf_reg, inbuf_next;
	logic [PORT_W-1:0] flat_reg, flat_next, slat_reg, slat_next;
	logic [PORT_W-1:0] ctrl_val;
	logic slave_wr;

	assign slave_wr = SLAVE_WR_STROBE_IN & mode_reg;
	assign ctrl_val = {ibf_reg, obf_reg, input_word_overrun_reg, mode_reg, 1'b0,
		edir_reg};

	always_comb begin
		ack_next = req & ~ack_reg;
		rdata_next = rdata_reg;
		if (req & ~ack_reg & AVS_READ_IN) begin
			case (AVS_ADDRESS_IN)
				OFF_FIRST_PINS: rdata_next = first_lvl;
				OFF_FIRST_LATCH: rdata_next = flat_reg;
				OFF_FIRST_DIR: rdata_next = fdir_reg;
				// slave mode hands the received word to software
				OFF_SECOND_PINS: rdata_next = mode_reg ? inbuf_reg : second_lvl;
				OFF_SECOND_LATCH: rdata_next = slat_reg;
				OFF_SECOND_DIR: rdata_next = sdir_reg;
				OFF_PORT_E_CTRL: rdata_next = ctrl_val;
				default: rdata_next = '0;
			endcase
		end
	end

	// direction, mode and slave bus flag writes; overrides never land here
	always_comb begin
		fdir_next = wr_f_dir ? wd : fdir_reg;
		sdir_next = wr_s_dir ? wd : sdir_reg;
		edir_next = wr_ctrl ? wd[CTRL_DIR_MSB:0] : edir_reg;
		mode_next = wr_ctrl ? wd[CTRL_MODE_BIT] : mode_reg;
		// set wins over any clear in the same cycle
		ibf_next = slave_wr | (ibf_reg & ~(rd_s_pins & mode_reg));
		obf_next = (mode_reg & (wr_s_pins | wr_s_lat)) |
			(obf_reg & ~(SLAVE_RD_STROBE_IN & mode_reg));
		input_word_overrun_next = (slave_wr & ibf_reg) |
			(wr_ctrl ? wd[CTRL_OVERRUN_BIT] : input_word_overrun_reg);
		// an unread word is kept; the late one is dropped and flagged
		inbuf_next = (slave_wr & ~ibf_reg) ? second_lvl : inbuf_reg;
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			ack_reg <= 1'b0;
			rdata_reg <= '0;
			fdir_reg <= DIR_RST;
			sdir_reg <= DIR_RST;
			edir_reg <= CTRL_RST[CTRL_DIR_MSB:0];
			mode_reg <= CTRL_RST[CTRL_MODE_BIT];
			ibf_reg <= CTRL_RST[CTRL_IN_FULL_BIT];
			obf_reg <= CTRL_RST[CTRL_OUT_FULL_BIT];
			input_word_overrun_reg <= CTRL_RST[CTRL_OVERRUN_BIT];
			inbuf_reg <= '0;
		end else if (CLK_EN_IN) begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			fdir_reg <= fdir_next;
			sdir_reg <= sdir_next;
			edir_reg <= edir_next;
			mode_reg <= mode_next;
			ibf_reg <= ibf_next;
			obf_reg <= obf_next;
			input_word_overrun_reg <= input_word_overrun_next;
			inbuf_reg <= inbuf_next;
		end
	end

	// output latches: writes to pins or latch address both land here
	always_comb begin
		flat_next = (wr_f_pins | wr_f_lat) ? wd : flat_reg;
		slat_next = (wr_s_pins | wr_s_lat) ? wd : slat_reg;
	end

	// no reset on purpose: latch contents survive a warm reset
	always_ff @(posedge CORE_CLK_IN) begin
		if (CLK_EN_IN) begin
			flat_reg <= flat_next;
			slat_reg <= slat_next;
		end
	end

	// first port: peripheral merge, unit2 joins on its routed pin
	logic [PORT_W-1:0] sel_eff, pout_eff, poe_eff, f_oe, f_val;
	logic ccu2_on;
	assign ccu2_on = CCU2_PIN_ROUTE_IN & CCU2_SEL_IN;

	always_comb begin
		sel_eff = PERIPH_SEL_IN;
		pout_eff = PERIPH_OUT_IN;
		poe_eff = PERIPH_OE_IN;
		if (ccu2_on) begin
			sel_eff[CCU2_PIN] = 1'b1;
			pout_eff[CCU2_PIN] = CCU2_OUT_IN;
			poe_eff[CCU2_PIN] = CCU2_OE_IN;
		end
		f_oe = (sel_eff & poe_eff) | (~sel_eff & ~fdir_reg);
		f_val = (sel_eff & pout_eff) | (~sel_eff & flat_reg);
	end

	// driven value gated by enable so an unset latch never leaks out
	assign FIRST_PIN_OE_OUT = f_oe;
	assign FIRST_PIN_OUT = f_oe & f_val;
	assign FIRST_PIN_LEVEL_OUT = first_lvl;

	// second port: slave bus drives the latch only when asked
	logic [PORT_W-1:0] s_oe;
	assign s_oe = mode_reg ? {PORT_W{SLAVE_DRIVE_IN}} : ~sdir_reg;
	assign SECOND_PIN_OE_OUT = s_oe;
	assign SECOND_PIN_OUT = s_oe & slat_reg;

	assign SLAVE_BUS_MODE_OUT = mode_reg;
	assign INPUT_WORD_FULL_OUT = ibf_reg;
	assign OUTPUT_WORD_FULL_OUT = obf_reg;
	assign INPUT_WORD_OVERRUN_OUT = input_word_overrun_reg;
	assign PORT_E_DIR_OUT = edir_reg;

	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);

	input_off_a: assert property (
		((~sel_eff & fdir_reg & FIRST_PIN_OE_OUT) == '0))
		else $error("input pin still driven");

	latch_drive_a: assert property (
		((~sel_eff & ~fdir_reg) & (FIRST_PIN_OUT ^ flat_reg)) == '0)
		else $error("output pin differs from latch");

	periph_force_a: assert property (
		((sel_eff & (FIRST_PIN_OE_OUT ^ poe_eff)) == '0) &&
		((sel_eff & FIRST_PIN_OE_OUT & (FIRST_PIN_OUT ^ pout_eff)) == '0))
		else $error("peripheral override not applied");

	dir_kept_a: assert property (
		!wr_f_dir |=> $stable(fdir_reg))
		else $error("direction changed without write");

	dir_reset_a: assert property (
		$past(!RSTN_IN) |-> fdir_reg == DIR_RST && sdir_reg == DIR_RST
		&& ctrl_val == CTRL_RST)
		else $error("reset values wrong");

	latch_read_a: assert property (
		rd_go && hit(AVS_ADDRESS_IN, OFF_FIRST_LATCH)
		|-> AVS_READDATA_OUT[PORT_W-1:0] == flat_reg)
		else $error("latch read returned other value");

	pins_write_a: assert property (
		wr_f_pins |=> flat_reg == $past(wd))
		else $error("pins write missed latch");

	input_full_a: assert property (
		slave_wr && !ibf_reg && CLK_EN_IN
		|=> ibf_reg && inbuf_reg == $past(second_lvl))
		else $error("input word not captured");

	overrun_set_a: assert property (
		slave_wr && ibf_reg && CLK_EN_IN |=> input_word_overrun_reg && ibf_reg)
		else $error("overrun not flagged");

	slave_pins_a: assert property (
		mode_reg && SLAVE_DRIVE_IN |-> SECOND_PIN_OE_OUT == '1
		&& SECOND_PIN_OUT == slat_reg)
		else $error("slave bus not driving latch");

	bus_answer_a: assert property (
		req && AVS_WAITREQUEST_OUT && CLK_EN_IN |=> !AVS_WAITREQUEST_OUT
		|| !req)
		else $error("bus answer late");

	ccu2_route_c: cover property (ccu2_on && CCU2_OE_IN);
	overrun_c: cover property (slave_wr && ibf_reg);
	latch_rd_c: cover property (rd_go && hit(AVS_ADDRESS_IN, OFF_FIRST_LATCH));
	obf_clear_c: cover property (obf_reg ##1 !obf_reg);
endmodule // dbp_port

/* tb/dbp_pin_model.sv */
// dbp_pin_model: pin wires of both ports as seen from the board.
// assumes outside parts drive only the pins that the device leaves free.
`timescale 1ns/1ps
module dbp_pin_model (
	// device side, second port in the upper byte
	input wire logic [15:0] out_in,
	input wire logic [15:0] oe_in,
	// outside drivers
	input wire logic [15:0] ext_in,
	output logic [15:0] pin_out
);
	// no pull-ups: a released pin shows whatever the board drives
	assign pin_out = (oe_in & out_in) | (~oe_in & ext_in);
endmodule // dbp_pin_model

/* tb/dbp_port_test.sv */
// dbp_port_test: register, pin and slave bus tests of the dual byte port.
// assumes the pin model closes the loop from pin outputs to pin inputs.
`timescale 1ns/1ps
module dbp_port_test;
	import dbp_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] be = '0;
	logic [31:0] rdata;
	logic wait_o;
	logic [7:0] f_out, f_oe, s_out, s_oe, psel = '0, pout = '0, poe = '0;
	logic ce = 1'b1;
	logic [7:0] f_lvl;
	logic [2:0] e_dir;
	logic route = 1'b0, csel = 1'b0, cout = 1'b0, coe = 1'b0;
	logic swr = 1'b0, srd = 1'b0, sdrv = 1'b0;
	logic mode, ifull, ofull, ovr;
	logic [15:0] ext = '0;
	logic [15:0] pins;
	int err_total = 0;
	int cmp_count = 0;

	always #2 clk = ~clk;

	dbp_port u_dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CLK_EN_IN(ce),
		.AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_o),
		.FIRST_PIN_IN(pins[7:0]), .FIRST_PIN_OUT(f_out),
		.FIRST_PIN_OE_OUT(f_oe), .FIRST_PIN_LEVEL_OUT(f_lvl),
		.PERIPH_SEL_IN(psel), .PERIPH_OUT_IN(pout), .PERIPH_OE_IN(poe),
		.CCU2_PIN_ROUTE_IN(route), .CCU2_SEL_IN(csel), .CCU2_OUT_IN(cout),
		.CCU2_OE_IN(coe), .SECOND_PIN_IN(pins[15:8]),
		.SECOND_PIN_OUT(s_out), .SECOND_PIN_OE_OUT(s_oe),
		.SLAVE_WR_STROBE_IN(swr), .SLAVE_RD_STROBE_IN(srd),
		.SLAVE_DRIVE_IN(sdrv), .SLAVE_BUS_MODE_OUT(mode),
		.INPUT_WORD_FULL_OUT(ifull), .OUTPUT_WORD_FULL_OUT(ofull),
		.INPUT_WORD_OVERRUN_OUT(ovr), .PORT_E_DIR_OUT(e_dir));

	dbp_pin_model u_pins (.out_in({s_out, f_out}), .oe_in({s_oe, f_oe}),
		.ext_in(ext), .pin_out(pins));

	task automatic end_sim;
		$display("checks %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask

	// waitrequest is sampled at the rising edge that ends the cycle;
	// only the watchdog ends a wait that never finishes
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d, input logic [3:0] b, output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		wdata <= {24'h00_0000, d};
		be <= b;
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge clk);
		end while (wait_o !== 1'b0);
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic wr8(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, 4'hF, q);
	endtask

	task automatic rdc(input string nm, input logic [4:0] a,
		input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, 4'hF, q);
		chk(nm, e, q);
	endtask

	// one-cycle strobe: read side when rd_side is high, else write side
	task automatic pulse(input logic rd_side);
		@(posedge clk);
		if (rd_side) begin
			srd <= 1'b1;
		end else begin
			swr <= 1'b1;
		end
		@(posedge clk);
		srd <= 1'b0;
		swr <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		logic [7:0] q;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rdc("dir1", OFF_FIRST_DIR, DIR_RST);
		rdc("dir2", OFF_SECOND_DIR, DIR_RST);
		rdc("ctrl", OFF_PORT_E_CTRL, CTRL_RST);
		ext <= 16'h0099;
		@(negedge clk);
		chk("oe1", 8'h00, f_oe);
		chk("edir", CTRL_RST, {5'h00, e_dir});
		wr8(OFF_FIRST_LATCH, 8'hA5);
		wr8(OFF_FIRST_DIR, 8'hF0);
		repeat (6) @(negedge clk);
		chk("oe1", 8'h0F, f_oe);
		chk("out1", 8'h05, f_out);
		chk("lvl1", 8'h95, f_lvl);
		rdc("lat1", OFF_FIRST_LATCH, 8'hA5);
		rdc("pin1", OFF_FIRST_PINS, 8'h95);
		wr8(OFF_FIRST_PINS, 8'h3C);
		bus(1'b1, OFF_FIRST_LATCH, 8'hFF, 4'h0, q);
		rdc("lat1", OFF_FIRST_LATCH, 8'h3C);
		rdc("unmap", 5'h1C, 8'h00);
		// pin 6 forced out, pin 0 forced in, pin 7 enable unselected
		psel <= 8'h41;
		poe <= 8'hC0;
		pout <= 8'h41;
		route <= 1'b1;
		csel <= 1'b1;
		coe <= 1'b1;
		cout <= 1'b1;
		@(negedge clk);
		chk("oe1", 8'h4E, f_oe);
		chk("out1", 8'h4E, f_out);
		rdc("dir1", OFF_FIRST_DIR, 8'hF0);
		route <= 1'b0;
		@(negedge clk);
		chk("out1", 8'h4C, f_out);
		wr8(OFF_SECOND_LATCH, 8'h5A);
		wr8(OFF_SECOND_DIR, 8'hF0);
		@(negedge clk);
		chk("oe2", 8'h0F, s_oe);
		chk("out2", 8'h0A, s_out);
		rdc("lat2", OFF_SECOND_LATCH, 8'h5A);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdc("lat1", OFF_FIRST_LATCH, 8'h3C);
		rdc("dir1", OFF_FIRST_DIR, DIR_RST);
		ext <= 16'hC300;
		wr8(OFF_PORT_E_CTRL, 8'h17);
		repeat (6) @(negedge clk);
		chk("mode", 8'h01, {7'h00, mode});
		pulse(1'b0);
		chk("ifull", 8'h01, {7'h00, ifull});
		rdc("ctrl", OFF_PORT_E_CTRL, 8'h97);
		pulse(1'b0);
		chk("ovr", 8'h01, {7'h00, ovr});
		rdc("ctrl", OFF_PORT_E_CTRL, 8'hB7);
		wr8(OFF_PORT_E_CTRL, 8'h15);
		rdc("ctrl", OFF_PORT_E_CTRL, 8'h95);
		@(negedge clk);
		chk("ovr", 8'h00, {7'h00, ovr});
		chk("edir", 8'h05, {5'h00, e_dir});
		rdc("pin2", OFF_SECOND_PINS, 8'hC3);
		@(negedge clk);
		chk("ifull", 8'h00, {7'h00, ifull});
		// a frozen core must let a strobe pass unseen
		@(posedge clk);
		ce <= 1'b0;
		pulse(1'b0);
		chk("ifull", 8'h00, {7'h00, ifull});
		@(posedge clk);
		ce <= 1'b1;
		wr8(OFF_SECOND_LATCH, 8'h81);
		sdrv <= 1'b1;
		@(negedge clk);
		chk("ofull", 8'h01, {7'h00, ofull});
		chk("oe2", 8'hFF, s_oe);
		chk("out2", 8'h81, s_out);
		pulse(1'b1);
		chk("ofull", 8'h00, {7'h00, ofull});
		end_sim();
	end

	// about 130 cycles expected; cut a hang well past that
	initial begin
		#20000;
		err_total++;
		end_sim();
	end
endmodule // dbp_port_test
